// ===== hdl/pprm_defs.svh
// offsets, field positions and default values of the protected register map
`ifndef PPRM_DEFS_SVH
`define PPRM_DEFS_SVH

`define PPRM_LOWER_LAST     8'h7F
`define PPRM_USER_A_FIRST   8'h80
`define PPRM_USER_A_LAST    8'h83
`define PPRM_CONFIG         8'h84
`define PPRM_USER_B_FIRST   8'h85
`define PPRM_USER_B_LAST    8'h87
`define PPRM_ENTRY_FIRST    8'h88
`define PPRM_ENTRY_LAST     8'h8B
`define PPRM_SCRATCH_FIRST  8'h8C
`define PPRM_SCRATCH_LAST   8'h8E
`define PPRM_STATUS         8'h8F
`define PPRM_USER_PW_FIRST  8'h90
`define PPRM_USER_PW_LAST   8'h93
`define PPRM_MASTER_PW_FIRST 8'h94
`define PPRM_MASTER_PW_LAST 8'h97
`define PPRM_R0_BANK0       8'h98
`define PPRM_R1_BANK0       8'h99
`define PPRM_R2_BANK0       8'h9A
`define PPRM_SPARE          8'h9B
`define PPRM_R0_BANK1       8'h9C
`define PPRM_R1_BANK1       8'h9D
`define PPRM_R2_BANK1       8'h9E
`define PPRM_BUS_ADDR       8'h9F

`define PPRM_CFG_USED_MASK  8'h1F
`define PPRM_CFG_SHUNT_BIT  4
`define PPRM_CFG_BANK_BIT   3
`define PPRM_CFG_FLOAT2_BIT 2
`define PPRM_CFG_FLOAT1_BIT 1
`define PPRM_CFG_FLOAT0_BIT 0
`define PPRM_STAT_BANK_BIT  4
`define PPRM_STAT_FLOAT_BIT 0

`define PPRM_DEF_ZERO       8'h00
`define PPRM_DEF_RESISTOR   8'h7F
`define PPRM_DEF_BUS_ADDR   8'hA0
`define PPRM_DEF_PASSWORD   32'h00000000

`endif

// ===== hdl/pprm_pkg.sv
// types shared by the protected register map
package pprm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pprm_req_s;

  typedef struct packed {
    logic master;
    logic user;
  } pprm_level_s;

  typedef enum logic [2:0] {
    PPRM_RG_MASTER,
    PPRM_RG_USER,
    PPRM_RG_ENTRY,
    PPRM_RG_SCRATCH,
    PPRM_RG_STATUS,
    PPRM_RG_PASSWORD
  } pprm_region_e;

endpackage : pprm_pkg

// ===== hdl/pprm_access_check.sv
// region decode and password gating of one byte address
`include "pprm_defs.svh"
module pprm_access_check
  import pprm_pkg::*;
(
  input  wire logic [7:0]  addr_i,
  input  wire pprm_level_s level_i,
  output pprm_region_e     region_o,
  output logic             wr_allow_o,
  output logic             rd_allow_o,
  output logic             in_array_o
);

  wire in_user_a  = addr_i >= `PPRM_USER_A_FIRST
                 && addr_i <= `PPRM_USER_A_LAST;
  wire in_user_b  = addr_i >= `PPRM_USER_B_FIRST
                 && addr_i <= `PPRM_USER_B_LAST;
  wire in_config  = addr_i == `PPRM_CONFIG;
  wire in_entry   = addr_i >= `PPRM_ENTRY_FIRST
                 && addr_i <= `PPRM_ENTRY_LAST;
  wire in_scratch = addr_i >= `PPRM_SCRATCH_FIRST
                 && addr_i <= `PPRM_SCRATCH_LAST;
  wire in_status  = addr_i == `PPRM_STATUS;
  wire in_pw      = addr_i >= `PPRM_USER_PW_FIRST
                 && addr_i <= `PPRM_MASTER_PW_LAST;

  assign region_o = in_entry   ? PPRM_RG_ENTRY :
                    in_scratch ? PPRM_RG_SCRATCH :
                    in_status  ? PPRM_RG_STATUS :
                    in_pw      ? PPRM_RG_PASSWORD :
                    (in_user_a || in_user_b || in_config) ? PPRM_RG_USER :
                    PPRM_RG_MASTER;

  // master level also opens every user-level region
  assign wr_allow_o =
      (region_o == PPRM_RG_ENTRY) ||
      (region_o == PPRM_RG_SCRATCH) ||
      (region_o == PPRM_RG_USER
        && (level_i.user || level_i.master)) ||
      (region_o == PPRM_RG_MASTER && level_i.master) ||
      (region_o == PPRM_RG_PASSWORD && level_i.master);

  // password entry and settings never read back
  assign rd_allow_o = (region_o != PPRM_RG_ENTRY)
                   && (region_o != PPRM_RG_PASSWORD);
  assign in_array_o = region_o == PPRM_RG_MASTER
                   || region_o == PPRM_RG_USER
                   || region_o == PPRM_RG_SCRATCH;

endmodule // pprm_access_check

// ===== hdl/pprm_top.sv
// password protected byte register map of a triple variable resistor
`include "pprm_defs.svh"
module pprm_top
  import pprm_pkg::*;
#(
  parameter int NUM_BYTES = 256
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire pprm_req_s  req_i,
  input  wire logic       bank_select_pin_i,
  input  wire logic       global_float_pin_i,
  output logic [7:0]      rd_data_o,
  output logic            rd_valid_o,
  output logic            wr_ack_o,
  output logic [7:0]      resistor0_setting_o,
  output logic [7:0]      resistor1_setting_o,
  output logic [7:0]      resistor2_setting_o,
  output logic            bank_active_o,
  output logic [2:0]      resistor_float_o,
  output logic            shunt_switch_close_o
);

  // factory content of one array location
  function automatic logic [7:0] default_of(input int idx);
    logic [7:0] a;
    a = idx[7:0];
    if (a == `PPRM_R0_BANK0 || a == `PPRM_R1_BANK0
        || a == `PPRM_R2_BANK0 || a == `PPRM_R0_BANK1
        || a == `PPRM_R1_BANK1 || a == `PPRM_R2_BANK1) begin
      default_of = `PPRM_DEF_RESISTOR;
    end else if (a == `PPRM_BUS_ADDR) begin
      default_of = `PPRM_DEF_BUS_ADDR;
    end else begin
      default_of = `PPRM_DEF_ZERO;
    end
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_conf_reg;
  logic [1:0] pin_state_reg;
  wire  [1:0] pin_raw = {global_float_pin_i, bank_select_pin_i};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      pin_conf_reg <= 2'h0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_conf_reg <= pin_sync_reg;
    end
  end

  // a pin level is accepted only once two stages agree
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pin
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_state_reg[p] <= 1'b0;
        end else if (pin_sync_reg[p] == pin_conf_reg[p]) begin
          pin_state_reg[p] <= pin_conf_reg[p];
        end
      end
    end
  endgenerate

  wire bank_pin_state  = pin_state_reg[0];
  wire float_pin_state = pin_state_reg[1];

  // ---------------- password state ----------------
  logic [31:0] entry_reg;
  logic [31:0] user_pw_reg;
  logic [31:0] master_pw_reg;
  pprm_level_s level;

  // a zero setting matches the zero entry, so access is open from reset
  assign level.master = entry_reg == master_pw_reg;
  assign level.user   = entry_reg == user_pw_reg;

  // ---------------- access decode ----------------
  pprm_region_e region;
  logic         wr_allow;
  logic         rd_allow;
  logic         in_array;

  pprm_access_check u_check (
    .addr_i     (req_i.addr),
    .level_i    (level),
    .region_o   (region),
    .wr_allow_o (wr_allow),
    .rd_allow_o (rd_allow),
    .in_array_o (in_array)
  );

  wire         wr_go     = req_i.wr && wr_allow;
  wire [1:0]   byte_sel  = req_i.addr[1:0];
  wire [4:0]   lane_lsb  = 5'(8 * (3 - int'(byte_sel)));
  wire         is_master_pw = req_i.addr[2];
  wire         pw_wr     = wr_go && region == PPRM_RG_PASSWORD;
  wire         entry_wr  = wr_go && region == PPRM_RG_ENTRY;
  wire         array_wr  = wr_go && in_array;
  wire         is_config = req_i.addr == `PPRM_CONFIG;
  // unused configuration bits are never stored
  wire [7:0]   array_wdata = is_config
                           ? (req_i.wdata & `PPRM_CFG_USED_MASK)
                           : req_i.wdata;

  // lowest address carries the most significant byte
  function automatic logic [31:0] put_byte(input logic [31:0] word,
                                           input logic [4:0]  lsb,
                                           input logic [7:0]  data);
    logic [31:0] mask;
    mask = 32'h000000FF << lsb;
    put_byte = (word & ~mask) | (32'(data) << lsb);
  endfunction

  wire [31:0] entry_next  = put_byte(entry_reg, lane_lsb, req_i.wdata);
  wire [31:0] user_pw_next   = put_byte(user_pw_reg, lane_lsb,
                                        req_i.wdata);
  wire [31:0] master_pw_next = put_byte(master_pw_reg, lane_lsb,
                                        req_i.wdata);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_reg <= `PPRM_DEF_PASSWORD;
    end else if (entry_wr) begin
      entry_reg <= entry_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      user_pw_reg   <= `PPRM_DEF_PASSWORD;
      master_pw_reg <= `PPRM_DEF_PASSWORD;
    end else if (pw_wr) begin
      if (is_master_pw) begin
        master_pw_reg <= master_pw_next;
      end else begin
        user_pw_reg <= user_pw_next;
      end
    end
  end

  // ---------------- byte array ----------------
  // one flop byte per location; gated so refused writes change nothing
  logic [7:0] mem [NUM_BYTES];

  genvar i;
  generate
    for (i = 0; i < NUM_BYTES; i++) begin : g_mem
      wire hit = array_wr && req_i.addr == 8'(i);
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mem[i] <= default_of(i);
        end else if (hit) begin
          mem[i] <= array_wdata;
        end
      end
    end
  endgenerate

  // ---------------- read path ----------------
  wire [7:0] status_byte =
      {3'h0, bank_pin_state, 3'h0, float_pin_state};
  wire [7:0] rd_data_next =
      !rd_allow                  ? `PPRM_DEF_ZERO :
      region == PPRM_RG_STATUS   ? status_byte :
      mem[req_i.addr];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= `PPRM_DEF_ZERO;
      rd_valid_o <= 1'b0;
      wr_ack_o   <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd && !req_i.wr;
      wr_ack_o   <= req_i.wr;
      if (req_i.rd && !req_i.wr) begin
        rd_data_o <= rd_data_next;
      end
    end
  end

  // ---------------- resistor control ----------------
  wire [7:0] cfg       = mem[`PPRM_CONFIG];
  wire       bank_sel  = cfg[`PPRM_CFG_BANK_BIT] | bank_pin_state;
  wire [2:0] float_bits = {cfg[`PPRM_CFG_FLOAT2_BIT],
                           cfg[`PPRM_CFG_FLOAT1_BIT],
                           cfg[`PPRM_CFG_FLOAT0_BIT]};
  wire [2:0] float_next = float_pin_state ? 3'h7 : float_bits;
  wire [7:0] r0_next = bank_sel ? mem[`PPRM_R0_BANK1]
                                : mem[`PPRM_R0_BANK0];
  wire [7:0] r1_next = bank_sel ? mem[`PPRM_R1_BANK1]
                                : mem[`PPRM_R1_BANK0];
  wire [7:0] r2_next = bank_sel ? mem[`PPRM_R2_BANK1]
                                : mem[`PPRM_R2_BANK0];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resistor0_setting_o  <= `PPRM_DEF_RESISTOR;
      resistor1_setting_o  <= `PPRM_DEF_RESISTOR;
      resistor2_setting_o  <= `PPRM_DEF_RESISTOR;
      bank_active_o        <= 1'b0;
      resistor_float_o     <= 3'h0;
      shunt_switch_close_o <= 1'b0;
    end else begin
      resistor0_setting_o  <= r0_next;
      resistor1_setting_o  <= r1_next;
      resistor2_setting_o  <= r2_next;
      bank_active_o        <= bank_sel;
      resistor_float_o     <= float_next;
      shunt_switch_close_o <= cfg[`PPRM_CFG_SHUNT_BIT];
    end
  end

endmodule // pprm_top

// ===== dv/pprm_top_chk.sv
// port assertions of the protected register map
module pprm_top_chk
  import pprm_pkg::*;
#(
  parameter int NUM_BYTES = 256
) (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire pprm_req_s  req_i,
  input wire logic       bank_select_pin_i,
  input wire logic       global_float_pin_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rd_valid_o,
  input wire logic       wr_ack_o,
  input wire logic [7:0] resistor0_setting_o,
  input wire logic       bank_active_o,
  input wire logic [2:0] resistor_float_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd_only = req_i.rd && !req_i.wr;

  chk_ack_every: assert property (req_i.wr |=> wr_ack_o)
    else $error("write not acknowledged");
  chk_ack_only: assert property (!req_i.wr |=> !wr_ack_o)
    else $error("acknowledge without write");
  chk_read_answer: assert property (rd_only |=> rd_valid_o)
    else $error("read not answered");
  chk_data_hold: assert property (!rd_only |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  chk_entry_hidden: assert property (rd_only &&
    req_i.addr inside {[8'h88:8'h8B]} |=> rd_data_o == 8'h00)
    else $error("entry byte readable");
  chk_pw_hidden: assert property (rd_only &&
    req_i.addr inside {[8'h90:8'h97]} |=> rd_data_o == 8'h00)
    else $error("password setting readable");
  chk_status_zero: assert property (rd_only &&
    req_i.addr == 8'h8F |=> (rd_data_o & 8'hEE) == 8'h00)
    else $error("status spare bits set");
  chk_cfg_top: assert property (rd_only &&
    req_i.addr == 8'h84 |=> rd_data_o[7:5] == 3'h0)
    else $error("config top bits set");
  chk_float_all: assert property (global_float_pin_i [*6]
    |-> resistor_float_o == 3'h7)
    else $error("float pin not obeyed");
  chk_bank_pin: assert property (bank_select_pin_i [*6]
    |-> bank_active_o)
    else $error("bank pin not obeyed");

  cover property (req_i.wr && req_i.addr == 8'h84);
  cover property (rd_only && req_i.addr == 8'h8F);
  cover property (global_float_pin_i [*6]);
endmodule // pprm_top_chk

bind pprm_top pprm_top_chk #(.NUM_BYTES(NUM_BYTES)) pprm_top_chk_inst (
  .mclk_i, .rst_n_i, .req_i, .bank_select_pin_i, .global_float_pin_i,
  .rd_data_o, .rd_valid_o, .wr_ack_o, .resistor0_setting_o,
  .bank_active_o, .resistor_float_o);

// ===== dv/pprm_host_model.sv
// host model issuing byte requests to the register map
module pprm_host_model
  import pprm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       ack_i,
  input  wire logic       vld_i,
  input  wire logic [7:0] dat_i,
  output pprm_req_s       req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // one-cycle pulse; answer sampled on the edge after it is taken
  task automatic xfer(input logic [7:0] a, d, input logic w,
                      output logic ok, output logic [7:0] q);
    @(posedge clk_i);
    req_o <= '{a, d, w, !w};
    @(posedge clk_i);
    req_o <= '{~a, ~d, 1'b0, 1'b0};
    @(posedge clk_i);
    ok = w ? ack_i : vld_i;
    q = dat_i;
  endtask
endmodule // pprm_host_model

// ===== dv/test_pprm_top.sv
// self-checking bench of the protected register map
module test_pprm_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                mclk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                bank_select_pin_i = 1'b0;
  logic                global_float_pin_i = 1'b0;
  pprm_pkg::pprm_req_s req;
  logic [7:0]          rd_data_o, resistor0_setting_o;
  logic [7:0]          resistor1_setting_o, resistor2_setting_o;
  logic                rd_valid_o, wr_ack_o, bank_active_o;
  logic                shunt_switch_close_o;
  logic [2:0]          resistor_float_o;
  int                  mismatches = 0;
  int                  total_checks = 0;

  pprm_top pprm_top_inst (.mclk_i, .rst_n_i, .req_i(req),
    .bank_select_pin_i, .global_float_pin_i, .rd_data_o, .rd_valid_o,
    .wr_ack_o, .resistor0_setting_o, .resistor1_setting_o,
    .resistor2_setting_o, .bank_active_o, .resistor_float_o,
    .shunt_switch_close_o);
  pprm_host_model pprm_host_model_inst (.clk_i(mclk_i), .ack_i(wr_ack_o),
    .vld_i(rd_valid_o), .dat_i(rd_data_o), .req_o(req));

  initial forever #10 mclk_i = ~mclk_i;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, d);
    logic       ok;
    logic [7:0] q;
    pprm_host_model_inst.xfer(a, d, 1'b1, ok, q);
    cmp({7'h00, ok}, 8'h01);
  endtask
  task automatic r(input logic [7:0] a, e);
    logic       ok;
    logic [7:0] q;
    pprm_host_model_inst.xfer(a, 8'h00, 1'b0, ok, q);
    cmp({7'h00, ok}, 8'h01);
    cmp(q, e);
  endtask
  task automatic wr(input logic [7:0] a, d, e);
    w(a, d);
    r(a, e);
  endtask
  // most significant byte goes to the lowest address
  task automatic w4(input logic [7:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      w(a + i[7:0], v[31 - 8 * i -: 8]);
    end
  endtask
  task automatic o(input logic [7:0] a, b, c, input logic [2:0] f,
                   input logic k, s);
    #1;
    cmp(resistor0_setting_o, a);
    cmp(resistor1_setting_o, b);
    cmp(resistor2_setting_o, c);
    cmp({5'h00, resistor_float_o}, {5'h00, f});
    cmp({6'h00, bank_active_o, shunt_switch_close_o}, {6'h00, k, s});
  endtask

  task automatic t_defaults();
    r(8'h00, 8'h00);
    r(8'h85, 8'h00);
    r(8'h84, 8'h00);
    r(8'h8C, 8'h00);
    r(8'h98, 8'h7F);
    r(8'h9E, 8'h7F);
    r(8'h9F, 8'hA0);
    r(8'hA0, 8'h00);
    o(8'h7F, 8'h7F, 8'h7F, 3'h0, 1'b0, 1'b0);
    $display("defaults done");
  endtask
  task automatic t_open();
    wr(8'h10, 8'h55, 8'h55);
    wr(8'h8D, 8'h5A, 8'h5A);
    wr(8'h8F, 8'hFF, 8'h00);
    wr(8'h88, 8'h12, 8'h00);
    wr(8'h10, 8'h66, 8'h55);
    w(8'h88, 8'h00);
    $display("open access done");
  endtask
  task automatic t_cfg();
    wr(8'h84, 8'hFF, 8'h1F);
    o(8'h7F, 8'h7F, 8'h7F, 3'h7, 1'b1, 1'b1);
    w4(8'h9C, 32'h11223300);
    w(8'h9E, 8'h33);
    o(8'h11, 8'h22, 8'h33, 3'h7, 1'b1, 1'b1);
    w(8'h84, 8'h05);
    o(8'h7F, 8'h7F, 8'h7F, 3'h5, 1'b0, 1'b0);
    w(8'h84, 8'h00);
    $display("configuration done");
  endtask
  task automatic t_pins();
    @(posedge mclk_i);
    bank_select_pin_i <= 1'b1;
    global_float_pin_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    o(8'h11, 8'h22, 8'h33, 3'h7, 1'b1, 1'b0);
    r(8'h8F, 8'h11);
    bank_select_pin_i <= 1'b0;
    global_float_pin_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    o(8'h7F, 8'h7F, 8'h7F, 3'h0, 1'b0, 1'b0);
    $display("pins done");
  endtask
  task automatic t_pw();
    w4(8'h90, 32'h11223344);
    w(8'h94, 8'hA5);
    w(8'h95, 8'hBB);
    r(8'h90, 8'h00);
    r(8'h94, 8'h00);
    wr(8'h10, 8'h77, 8'h55);
    wr(8'h80, 8'h77, 8'h00);
    wr(8'h84, 8'h08, 8'h00);
    wr(8'h98, 8'h01, 8'h7F);
    wr(8'h8E, 8'h3C, 8'h3C);
    w4(8'h88, 32'h11223344);
    wr(8'h80, 8'h77, 8'h77);
    wr(8'h84, 8'h10, 8'h10);
    wr(8'h10, 8'h77, 8'h55);
    wr(8'h9B, 8'h01, 8'h00);
    w(8'h94, 8'h00);
    w4(8'h88, 32'hA5000000);
    wr(8'h10, 8'h77, 8'h77);
    wr(8'h86, 8'h99, 8'h99);
    wr(8'h98, 8'h01, 8'h01);
    wr(8'h9F, 8'hB2, 8'hB2);
    wr(8'hC0, 8'hC3, 8'hC3);
    $display("passwords done");
  endtask

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_defaults();
    t_open();
    t_cfg();
    t_pins();
    t_pw();
    stop_test();
  end
  // tests need well under 1000 cycles; this allows ten times that
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule // test_pprm_top
